// file: common/igfsh_defines.svh
// constant names for the glitch filter and stop holdoff block
// Function
// - holdoff enabled delays stop grant during bytes
// - finish current byte, then grant stop request
// - idle or disabled controller grants stop immediately
// - holdoff disabled never gates stop entry
// - pending complete interrupt raised after wake
// - bus stop condition sets stop flag
// - stop flag clears only on written one
// - stop interrupt enable gates stop interrupt
// - stop flag left set re-raises interrupt flag
// - five-bit factor sets suppressed glitch width
// - factor zero bypasses, 1..31 filter cycles
`ifndef IGFSH_DEFINES_SVH
`define IGFSH_DEFINES_SVH
// register indices, byte address is four times the index
`define IGFSH_IDX_CTRL 6'h00
`define IGFSH_IDX_STAT 6'h01
`define IGFSH_IDX_MASK 6'h02
`define IGFSH_IDX_GFS 6'h06
// filter and stop control register fields
`define IGFSH_GFS_HOLD_EN 7
`define IGFSH_GFS_STOP_SEEN 6
`define IGFSH_GFS_STOP_IE 5
`define IGFSH_GFS_FAC_HI 4
`define IGFSH_GFS_FAC_LO 0
// control register fields
`define IGFSH_CTRL_IRQ_EN 0
`define IGFSH_CTRL_ENABLE 1
// status and mask register fields
`define IGFSH_STAT_IRQF 0
`define IGFSH_STAT_XFER 1
`define IGFSH_STAT_ACK 2
`define IGFSH_STAT_BUSY 3
// reset values
`define IGFSH_FAC_RST 5'h00
`define IGFSH_MASK_RST 2'h0
`define IGFSH_LINE_RST 2'h3
// serial clocks per byte, eight data and one acknowledge
`define IGFSH_BITS_PER_BYTE 4'h9
`endif

// file: common/igfsh_pkg.sv
// shared types of the glitch filter and stop holdoff block
package igfsh_pkg;
  // stop request handshake, idle and acked differ in both bits
  typedef enum logic [1:0] {
    IGFSH_IDLE = 2'b00,
    IGFSH_WAIT = 2'b01,
    IGFSH_ACKED = 2'b11
  } igfsh_hold_t;
  // all state of the top module
  typedef struct packed {
    logic stop_holdoff_en;
    logic bus_stop_seen_flag;
    logic bus_stop_irq_en;
    logic [4:0] glitch_width_factor;
    logic ctrl_irq_en;
    logic ctrl_enable;
    logic ctrl_irq_flag;
    logic xfer_complete_flag;
    logic [1:0] mask;
    igfsh_hold_t hold;
    logic irq;
    logic [31:0] prdata;
    logic pslverr;
  } igfsh_core_t;
endpackage

// file: common/igfsh_line_if.sv
// filtered bus lines and bus events passed between block modules
`timescale 1ns/100ps
interface igfsh_line_if;
  logic [1:0] line;   // bit 0 serial clock, bit 1 serial data
  logic stop_seen;    // one-cycle pulse per stop condition
  logic byte_done;    // one-cycle pulse at end of byte
  logic byte_busy;    // a byte is on the wire
  modport filt (output line);
  modport watch (input line, output stop_seen, byte_done, byte_busy);
  modport core (input line, stop_seen, byte_done, byte_busy);
endinterface

// file: hdl/igfsh_glitch_filter.sv
// programmable glitch filter for the serial clock and data inputs
`timescale 1ns/100ps
`include "igfsh_defines.svh"
module igfsh_glitch_filter #(
  parameter int LINES = 2,
  parameter int CW = 5
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins and width setting
  input wire logic [LINES-1:0] pin_in,
  input wire logic [CW-1:0] factor,
  // filtered lines
  igfsh_line_if.filt lines
);
  // refuse shapes the line carrier cannot hold
  if (LINES != 2 || CW < 1) begin : g_check
    $error("igfsh_glitch_filter: unsupported LINES or CW");
  end
  // all filter state
  typedef struct packed {
    logic [LINES-1:0] meta;
    logic [LINES-1:0] sync;
    logic [LINES-1:0] out;
    logic [LINES-1:0][CW-1:0] cnt;
  } igfsh_filt_t;
  igfsh_filt_t cur, next_cur;
  // each line filtered alike and on its own
  always_comb begin
    next_cur = cur;
    next_cur.meta = pin_in;
    next_cur.sync = cur.meta;
    for (int i = 0; i < LINES; i++) begin
      if (cur.sync[i] == cur.out[i]) begin
        next_cur.cnt[i] = '0;
      end else if (factor == '0 || cur.cnt[i] >= factor) begin
        // bypass, or level held longer than factor cycles
        next_cur.out[i] = cur.sync[i];
        next_cur.cnt[i] = '0;
      end else begin
        next_cur.cnt[i] = cur.cnt[i] + 1'b1;
      end
    end
  end
  // state register, lines idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{meta: `IGFSH_LINE_RST, sync: `IGFSH_LINE_RST, out: `IGFSH_LINE_RST, cnt: '0};
    end else begin
      cur <= next_cur;
    end
  end
  assign lines.line = cur.out;
endmodule // igfsh_glitch_filter

// file: hdl/igfsh_bus_watch.sv
// start, stop and byte progress detection on the filtered lines
`timescale 1ns/100ps
`include "igfsh_defines.svh"
module igfsh_bus_watch (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filtered lines in, events out
  igfsh_line_if.watch lines
);
  // all watcher state
  typedef struct packed {
    logic [1:0] prev;
    logic in_frame;
    logic [3:0] bits;
    logic stop_p;
    logic done_p;
  } igfsh_watch_t;
  igfsh_watch_t cur, next_cur;
  logic scl, sda;
  assign scl = lines.line[0];
  assign sda = lines.line[1];
  // edge and condition detection
  always_comb begin
    next_cur = cur;
    next_cur.prev = lines.line;
    next_cur.stop_p = 1'b0;
    next_cur.done_p = 1'b0;
    if (scl && cur.prev[0] && !sda && cur.prev[1]) begin
      // start or repeated start
      next_cur.in_frame = 1'b1;
      next_cur.bits = '0;
    end else if (scl && cur.prev[0] && sda && !cur.prev[1]) begin
      // stop condition
      next_cur.in_frame = 1'b0;
      next_cur.bits = '0;
      next_cur.stop_p = 1'b1;
    end else if (cur.in_frame && scl && !cur.prev[0]) begin
      next_cur.bits = cur.bits + 1'b1;
    end else if (!scl && cur.prev[0] && cur.bits == `IGFSH_BITS_PER_BYTE) begin
      // acknowledge clock ended, byte finished
      next_cur.bits = '0;
      next_cur.done_p = 1'b1;
    end
  end
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{prev: `IGFSH_LINE_RST, in_frame: 1'b0, bits: '0, stop_p: 1'b0, done_p: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end
  assign lines.stop_seen = cur.stop_p;
  assign lines.byte_done = cur.done_p;
  assign lines.byte_busy = (cur.bits != '0);
endmodule // igfsh_bus_watch

// file: hdl/igfsh_top.sv
// glitch filter, stop holdoff and stop detect block with apb registers
`timescale 1ns/100ps
`include "igfsh_defines.svh"
module igfsh_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire bus pins, input side only
  input wire logic scl_in,
  input wire logic sda_in,
  // filtered lines for the rest of the controller
  output logic scl_filt,
  output logic sda_filt,
  // low-power handshake
  input wire logic stop_req,
  output logic stop_ack,
  // controller flags and interrupt
  output logic ctrl_irq_en,
  output logic xfer_complete_flag,
  output logic ctrl_irq_flag,
  output logic irq
);

  // ==========================================================
  // address decoding
  // ==========================================================

  // one decode shared by read and write
  function automatic logic [3:0] igfsh_decode(input logic [7:0] addr);
    logic [3:0] hit;
    hit = 4'h0;
    if (addr[1:0] != 2'h0) begin
      hit = 4'h0;  // misaligned, unmapped
    end else if (addr[7:2] == `IGFSH_IDX_CTRL) begin
      hit = 4'h1;
    end else if (addr[7:2] == `IGFSH_IDX_STAT) begin
      hit = 4'h2;
    end else if (addr[7:2] == `IGFSH_IDX_MASK) begin
      hit = 4'h4;
    end else if (addr[7:2] == `IGFSH_IDX_GFS) begin
      hit = 4'h8;
    end
    return hit;
  endfunction

  // ==========================================================
  // submodules
  // ==========================================================

  igfsh_line_if lines ();  // filtered lines and bus events

  igfsh_pkg::igfsh_core_t cur;       // registered state
  igfsh_pkg::igfsh_core_t next_cur;  // next state

  // glitch filter on both lines
  igfsh_glitch_filter #(
    .LINES(2),
    .CW(5)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({sda_in, scl_in}),
    .factor(cur.glitch_width_factor),
    .lines(lines.filt)
  );

  // start, stop and byte tracking
  igfsh_bus_watch u_watch (
    .pclk(pclk),
    .presetn(presetn),
    .lines(lines.watch)
  );

  // ==========================================================
  // apb phase decoding
  // ==========================================================

  logic [3:0] hit;     // decoded register select
  logic setup_ph;      // first cycle of a transfer
  logic wr_access;     // write takes effect on this edge
  logic wr_lane0;      // low byte lane written
  logic [7:0] wbyte;   // low byte of write data
  logic busy;          // byte on the wire
  logic grant;         // stop request may be acknowledged
  logic [3:0] stat_rd; // status read view

  assign hit = igfsh_decode(paddr);
  assign setup_ph = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign wr_lane0 = wr_access && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign busy = lines.byte_busy;

  // ==========================================================
  // stop mode handshake
  // ==========================================================

  // grant when holdoff is off, or the bus is between bytes
  always_comb begin
    if (!cur.stop_holdoff_en) begin
      grant = 1'b1;                  // never gated
    end else if (cur.hold == igfsh_pkg::IGFSH_ACKED) begin
      grant = 1'b1;                  // stays granted until released
    end else if (!cur.ctrl_enable || !busy) begin
      grant = 1'b1;                  // idle, disabled or byte done
    end else begin
      grant = 1'b0;                  // byte in progress, hold off
    end
  end

  // acknowledge follows the request once granted
  assign stop_ack = stop_req && grant;

  // status view shared by read data
  assign stat_rd = {busy, stop_ack, cur.xfer_complete_flag, cur.ctrl_irq_flag};

  // ==========================================================
  // next state
  // ==========================================================

  always_comb begin
    next_cur = cur;

    // handshake state machine
    case (cur.hold)
      igfsh_pkg::IGFSH_IDLE: begin
        if (stop_req && grant) begin
          next_cur.hold = igfsh_pkg::IGFSH_ACKED;
        end else if (stop_req) begin
          next_cur.hold = igfsh_pkg::IGFSH_WAIT;
        end
      end
      igfsh_pkg::IGFSH_WAIT: begin
        if (!stop_req) begin
          next_cur.hold = igfsh_pkg::IGFSH_IDLE;  // request withdrawn
        end else if (grant) begin
          next_cur.hold = igfsh_pkg::IGFSH_ACKED;  // byte finished
        end
      end
      igfsh_pkg::IGFSH_ACKED: begin
        if (!stop_req) begin
          next_cur.hold = igfsh_pkg::IGFSH_IDLE;  // woken
        end
      end
      default: begin
        next_cur.hold = igfsh_pkg::IGFSH_IDLE;
      end
    endcase

    // register writes, one-to-clear before hardware sets
    if (wr_lane0) begin
      if (hit[0]) begin
        next_cur.ctrl_irq_en = wbyte[`IGFSH_CTRL_IRQ_EN];
        next_cur.ctrl_enable = wbyte[`IGFSH_CTRL_ENABLE];
      end else if (hit[1]) begin
        if (wbyte[`IGFSH_STAT_IRQF]) begin
          next_cur.ctrl_irq_flag = 1'b0;
        end
        if (wbyte[`IGFSH_STAT_XFER]) begin
          next_cur.xfer_complete_flag = 1'b0;
        end
      end else if (hit[2]) begin
        next_cur.mask = wbyte[`IGFSH_STAT_XFER:`IGFSH_STAT_IRQF];
      end else if (hit[3]) begin
        next_cur.stop_holdoff_en = wbyte[`IGFSH_GFS_HOLD_EN];
        next_cur.bus_stop_irq_en = wbyte[`IGFSH_GFS_STOP_IE];
        next_cur.glitch_width_factor = wbyte[`IGFSH_GFS_FAC_HI:`IGFSH_GFS_FAC_LO];
        if (wbyte[`IGFSH_GFS_STOP_SEEN]) begin
          next_cur.bus_stop_seen_flag = 1'b0;  // a zero leaves it
        end
      end
    end

    // hardware sets win over a clear in the same cycle
    if (lines.stop_seen) begin
      next_cur.bus_stop_seen_flag = 1'b1;
    end
    if (lines.byte_done) begin
      next_cur.xfer_complete_flag = 1'b1;
      if (cur.ctrl_irq_en) begin
        next_cur.ctrl_irq_flag = 1'b1;
      end
    end

    // a stop flag still set keeps raising the interrupt flag
    if (cur.bus_stop_seen_flag && cur.bus_stop_irq_en) begin
      next_cur.ctrl_irq_flag = 1'b1;
    end

    // on wake, deliver a completion pending from before stop
    if (cur.hold == igfsh_pkg::IGFSH_ACKED && !stop_req) begin
      if (cur.ctrl_irq_en && cur.xfer_complete_flag) begin
        next_cur.ctrl_irq_flag = 1'b1;
      end
    end

    // interrupt line from unmasked status
    next_cur.irq = |({cur.xfer_complete_flag, cur.ctrl_irq_flag} & cur.mask);

    // read data and error captured in the setup cycle
    if (setup_ph) begin
      next_cur.prdata = 32'h0000_0000;
      next_cur.pslverr = 1'b0;
      if (hit[0]) begin
        next_cur.prdata[`IGFSH_CTRL_IRQ_EN] = cur.ctrl_irq_en;
        next_cur.prdata[`IGFSH_CTRL_ENABLE] = cur.ctrl_enable;
      end else if (hit[1]) begin
        next_cur.prdata[`IGFSH_STAT_BUSY:`IGFSH_STAT_IRQF] = stat_rd;
      end else if (hit[2]) begin
        next_cur.prdata[`IGFSH_STAT_XFER:`IGFSH_STAT_IRQF] = cur.mask;
      end else if (hit[3]) begin
        next_cur.prdata[`IGFSH_GFS_HOLD_EN] = cur.stop_holdoff_en;
        next_cur.prdata[`IGFSH_GFS_STOP_SEEN] = cur.bus_stop_seen_flag;
        next_cur.prdata[`IGFSH_GFS_STOP_IE] = cur.bus_stop_irq_en;
        next_cur.prdata[`IGFSH_GFS_FAC_HI:`IGFSH_GFS_FAC_LO] = cur.glitch_width_factor;
      end else begin
        next_cur.pslverr = 1'b1;  // unmapped address
      end
    end
  end

  // ==========================================================
  // state register
  // ==========================================================

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{
        stop_holdoff_en: 1'b0,
        bus_stop_seen_flag: 1'b0,
        bus_stop_irq_en: 1'b0,
        glitch_width_factor: `IGFSH_FAC_RST,
        ctrl_irq_en: 1'b0,
        ctrl_enable: 1'b0,
        ctrl_irq_flag: 1'b0,
        xfer_complete_flag: 1'b0,
        mask: `IGFSH_MASK_RST,
        hold: igfsh_pkg::IGFSH_IDLE,
        irq: 1'b0,
        prdata: 32'h0000_0000,
        pslverr: 1'b0
      };
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================

  assign pready = 1'b1;  // every access completes without wait
  assign prdata = cur.prdata;
  assign pslverr = cur.pslverr;
  assign scl_filt = lines.line[0];
  assign sda_filt = lines.line[1];
  assign ctrl_irq_en = cur.ctrl_irq_en;
  assign xfer_complete_flag = cur.xfer_complete_flag;
  assign ctrl_irq_flag = cur.ctrl_irq_flag;
  assign irq = cur.irq;

endmodule // igfsh_top

// file: sim/igfsh_properties.sv
// port assertions of the glitch filter and stop holdoff block
`timescale 1ns/100ps
`include "igfsh_defines.svh"
module igfsh_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // pins and filtered lines
  input wire logic scl_in,
  input wire logic scl_filt,
  input wire logic sda_filt,
  // handshake and flags
  input wire logic stop_req,
  input wire logic stop_ack,
  input wire logic ctrl_irq_en,
  input wire logic xfer_complete_flag,
  input wire logic ctrl_irq_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // shadow state
  logic wr; // a write commits at this edge
  logic [4:0] fac; // filter factor copy
  logic hold_on; // holdoff copy
  logic stop_ie; // stop irq enable copy
  logic en; // controller enable copy
  logic [2:0] up; // cycles since reset, saturating
  logic [5:0] run; // cycles raw clock pin held still
  logic scl_q; // last raw clock pin
  assign wr = psel && penable && pwrite && pstrb[0];
  // follow committed writes and pin activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hold_on, stop_ie, fac, en, up, run, scl_q} <= '0;
    end else begin
      up <= (up == 3'h7) ? up : up + 3'h1;
      scl_q <= scl_in;
      run <= (scl_in != scl_q) ? 6'h00 : (run == 6'h3F) ? run : run + 6'h01;
      if (wr && paddr == {`IGFSH_IDX_GFS, 2'h0}) begin
        {hold_on, stop_ie, fac} <= {pwdata[7], pwdata[5], pwdata[4:0]};
      end
      if (wr && paddr == {`IGFSH_IDX_CTRL, 2'h0}) begin
        en <= pwdata[1];
      end
    end
  end
  // ==========
  // assertions
  ack_needs_req_a: assert property (stop_ack |-> stop_req)
    else $error("stop grant without request");
  ack_held_a: assert property (stop_ack ##1 stop_req |-> stop_ack)
    else $error("stop grant withdrawn");
  idle_grant_a: assert property (!en |-> stop_ack == stop_req)
    else $error("disabled controller delayed grant");
  holdoff_off_a: assert property (!hold_on |-> stop_ack == stop_req)
    else $error("grant gated without holdoff");
  bypass_path_a: assert property (up == 3'h7 && fac == 5'h00 && $past(fac, 4) == 5'h00
    |-> scl_filt == $past(scl_in, 3))
    else $error("bypass path wrong");
  glitch_width_a: assert property (up == 3'h7 && fac != 5'h00 && $changed(scl_filt)
    |-> $past(run, 3) + 6'h02 >= {1'h0, fac})
    else $error("short pulse passed filter");
  stop_irq_a: assert property ($rose(sda_filt) && scl_filt && stop_ie
    |-> ##[1:5] ctrl_irq_flag)
    else $error("stop did not raise irq flag");
  irqf_clear_a: assert property ($fell(ctrl_irq_flag) |->
    $past(wr && paddr == {`IGFSH_IDX_STAT, 2'h0} && pwdata[0]))
    else $error("irq flag fell without clear");
  wake_irq_a: assert property ($fell(stop_req) && ctrl_irq_en && xfer_complete_flag
    |-> ##[0:2] ctrl_irq_flag)
    else $error("no irq after wake");
  // main scenarios
  cover property (stop_req && !stop_ack);
  cover property ($rose(sda_filt) && scl_filt);
  cover property ($fell(ctrl_irq_flag));
endmodule // igfsh_properties
bind igfsh_top igfsh_properties i_igfsh_properties (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .scl_in(scl_in),
  .scl_filt(scl_filt), .sda_filt(sda_filt), .stop_req(stop_req), .stop_ack(stop_ack),
  .ctrl_irq_en(ctrl_irq_en), .xfer_complete_flag(xfer_complete_flag),
  .ctrl_irq_flag(ctrl_irq_flag)
);

// file: sim/igfsh_bus_peer.sv
// behavioural peer on the two-wire bus, drives the raw pins
`timescale 1ns/100ps
module igfsh_bus_peer #(
  parameter int HALF = 40
) (
  // clock
  input wire logic pclk,
  // raw pins, pulled up when released
  output logic scl_in,
  output logic sda_in
);
  // ==========
  // bus primitives
  // lines start released
  initial begin
    scl_in = 1'h1;
    sda_in = 1'h1;
  end
  // wait whole cycles
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // start or repeated start, clock left low
  task automatic start();
    sda_in <= 1'h1;
    hold(HALF);
    scl_in <= 1'h1;
    hold(HALF);
    sda_in <= 1'h0;
    hold(HALF);
    scl_in <= 1'h0;
    hold(HALF);
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic send(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda_in <= (i == 0) ? 1'h0 : b[i-1];
      hold(HALF);
      scl_in <= 1'h1;
      hold(HALF);
      scl_in <= 1'h0;
      hold(HALF / 2);
    end
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_in <= 1'h0;
    hold(HALF);
    scl_in <= 1'h1;
    hold(HALF);
    sda_in <= 1'h1;
    hold(HALF);
  endtask
  // low pulse of w cycles on one line
  task automatic glitch(input logic ln, input int w);
    if (ln) sda_in <= 1'h0;
    else scl_in <= 1'h0;
    hold(w);
    sda_in <= 1'h1;
    scl_in <= 1'h1;
    hold(1);
  endtask
endmodule // igfsh_bus_peer

// file: sim/igfsh_top_tb_top.sv
// self-checking bench of the glitch filter and stop holdoff block
`timescale 1ns/100ps
`include "igfsh_defines.svh"
module igfsh_top_tb_top;
  // ==========
  // stimulus and observed signals
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF; // always full word
  logic stop_req = 1'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, scl_in, sda_in, scl_filt, sda_filt, stop_ack;
  logic ctrl_irq_en, xfer_complete_flag, ctrl_irq_flag, irq;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [7:0] A_CTRL = {`IGFSH_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_STAT = {`IGFSH_IDX_STAT, 2'h0};
  localparam logic [7:0] A_MASK = {`IGFSH_IDX_MASK, 2'h0};
  localparam logic [7:0] A_GFS = {`IGFSH_IDX_GFS, 2'h0};
  // filter table: factor, pulse width, pulse expected through
  logic [4:0] fac_t [5] = '{5'h00, 5'h05, 5'h05, 5'h1F, 5'h1F};
  int wid_t [5] = '{1, 5, 6, 31, 32};
  logic ok_t [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  always #4 pclk = ~pclk;
  igfsh_top i_igfsh_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
    .scl_filt(scl_filt), .sda_filt(sda_filt), .stop_req(stop_req), .stop_ack(stop_ack),
    .ctrl_irq_en(ctrl_irq_en), .xfer_complete_flag(xfer_complete_flag),
    .ctrl_irq_flag(ctrl_irq_flag), .irq(irq));
  igfsh_bus_peer i_igfsh_bus_peer (.pclk(pclk), .scl_in(scl_in), .sda_in(sda_in));
  // ==========
  // tasks
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, result left in q and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // one pulse against one filter setting
  task automatic filt_chk(input logic ln, input int w, input logic [4:0] f, input logic ok);
    logic seen;
    seen = 1'h0;
    apb(1'h1, A_GFS, {27'h0, f});
    fork
      i_igfsh_bus_peer.glitch(ln, w);
      repeat (w + 40) begin
        @(posedge pclk);
        if ((ln ? sda_filt : scl_filt) === 1'h0) seen = 1'h1;
      end
    join
    chk(seen, ok);
  endtask
  // counts and verdict
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========
  // test sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, A_GFS, 0);
    chk(q, 0);
    apb(1'h0, 8'h0C, 0);
    chk({q[30:0], err}, 32'h1);
    $display("reset and map test done");
    for (int i = 0; i < 10; i++) filt_chk(i[0], wid_t[i/2], fac_t[i/2], ok_t[i/2]);
    $display("filter test done");
    apb(1'h1, A_GFS, 32'h60);
    apb(1'h1, A_MASK, 32'h1);
    apb(1'h1, A_CTRL, 32'h2);
    i_igfsh_bus_peer.start();
    i_igfsh_bus_peer.send(8'h5A);
    i_igfsh_bus_peer.stop();
    apb(1'h0, A_GFS, 0);
    chk(q, 32'h60);
    chk({ctrl_irq_flag, irq}, 2'h3);
    apb(1'h1, A_STAT, 32'h1);
    apb(1'h0, A_STAT, 0);
    chk(q[0], 1);
    apb(1'h1, A_GFS, 32'h20);
    apb(1'h0, A_GFS, 0);
    chk(q[6], 1);
    apb(1'h1, A_MASK, 32'h0);
    apb(1'h0, A_STAT, 0);
    chk(irq, 0);
    apb(1'h1, A_GFS, 32'h40);
    apb(1'h1, A_STAT, 32'h3);
    apb(1'h0, A_STAT, 0);
    chk(q[1:0], 0);
    i_igfsh_bus_peer.start();
    i_igfsh_bus_peer.stop();
    chk(ctrl_irq_flag, 0);
    $display("stop detect test done");
    apb(1'h1, A_CTRL, 32'h3);
    apb(1'h1, A_GFS, 32'hC0);
    i_igfsh_bus_peer.start();
    fork
      i_igfsh_bus_peer.send(8'hC3);
      begin
        repeat (200) @(posedge pclk);
        stop_req <= 1'h1;
        @(posedge pclk);
        chk(stop_ack, 0);
        for (int n = 0; n < 2000 && stop_ack !== 1'h1; n++) @(posedge pclk);
        // look between edges, once the completion flag has settled
        repeat (2) @(negedge pclk);
        chk({stop_ack, xfer_complete_flag}, 2'h3);
        // drop the byte's own interrupt so only the wake can raise it again
        apb(1'h1, A_STAT, 32'h1);
      end
    join
    stop_req <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(ctrl_irq_flag, 1);
    i_igfsh_bus_peer.stop();
    apb(1'h1, A_STAT, 32'h3);
    stop_req <= 1'h1;
    @(posedge pclk);
    chk(stop_ack, 1);
    stop_req <= 1'h0;
    $display("holdoff test done");
    apb(1'h1, A_GFS, 32'h0);
    i_igfsh_bus_peer.start();
    fork
      i_igfsh_bus_peer.send(8'h96);
      begin
        repeat (200) @(posedge pclk);
        stop_req <= 1'h1;
        @(posedge pclk);
        chk(stop_ack, 1);
        stop_req <= 1'h0;
      end
    join
    // cut transfer restarts with the address
    i_igfsh_bus_peer.start();
    i_igfsh_bus_peer.send(8'hA4);
    i_igfsh_bus_peer.stop();
    $display("no holdoff test done");
    give_verdict();
  end
endmodule // igfsh_top_tb_top
